/* tbp_regs.vh */
// Summary of operation
// [R1] one token equals one byte of length
// [R2] bucket level capped at configured size
// [R3] tokens added at constant configured rate
// [R4] single bucket: send only if tokens cover length
// [R5] sent packet removes its length in tokens
// [R6] shaping holds packet until tokens suffice
// [R7] policing drops or marks uncovered packets
// [R8] software keeps bucket within interface bandwidth
// [R9] committed overflow spills into excess bucket
// [R10] single rate: committed covers length gives green
// [R11] single rate: green deducts committed bucket
// [R12] single rate: excess covers gives yellow, else red
// [R13] discarded packets leave all buckets untouched
// [R14] colour codes loss priority, red highest
// [R15] two rate: both buckets refill independently
// [R16] software sets peak rate at least committed
// [R17] two rate: peak short gives red, droppable
// [R18] two rate: committed covers green, else yellow
// [R19] mark writes 6-bit code, low bits kept
// [R20] two rate: green deducts both, yellow peak
// [R21] mode field selects one of four modes
`ifndef TBP_REGS_VH
`define TBP_REGS_VH
`define TBP_ADDR_CTRL 8'h00
`define TBP_ADDR_COMMITTED_RATE 8'h04
`define TBP_ADDR_PEAK_RATE 8'h08
`define TBP_ADDR_COMMITTED_BUCKET 8'h0C
`define TBP_ADDR_EXCESS_BUCKET 8'h10
`define TBP_ADDR_PEAK_BUCKET 8'h14
`define TBP_ADDR_DSCP 8'h18
`define TBP_ADDR_LEVEL_C 8'h1C
`define TBP_ADDR_LEVEL_S 8'h20
`define TBP_ADDR_CNT_GREEN 8'h24
`define TBP_ADDR_CNT_YELLOW 8'h28
`define TBP_ADDR_CNT_RED 8'h2C
`define TBP_ADDR_CNT_DROP 8'h30
`define TBP_CTRL_MODE_LO 0
`define TBP_CTRL_MODE_HI 1
`define TBP_CTRL_POLICE_MARK 2
`define TBP_CTRL_RED_DROP 3
`define TBP_CTRL_RESET 32'h0000_0000
`define TBP_RATE_RESET 32'h0001_0000
`define TBP_SIZE_RESET 32'h0000_2800
`define TBP_DSCP_RESET 32'h0000_0000
`define TBP_MODE_SHAPE 2'h0
`define TBP_MODE_POLICE 2'h1
`define TBP_MODE_SINGLE_RATE_THREE_COLOUR_MODE 2'h2
`define TBP_MODE_TWO_RATE_THREE_COLOUR_MODE 2'h3
`define TBP_COLOUR_GREEN 2'h0
`define TBP_COLOUR_YELLOW 2'h1
`define TBP_COLOUR_RED 2'h2
`endif

/* tbp_bucket.v */
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_bucket(
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire [31:0] rate,
	input wire [31:0] size,
	input wire [31:0] spill_in,
	input wire take,
	input wire [15:0] take_len,
	output reg [31:0] level,
	output wire [31:0] spill_out
);
	// rate is 16.16 tokens per cycle; the fraction carries so slow rates stay exact
	reg [15:0] frac;
	wire [16:0] frac_sum;
	wire [33:0] fill;
	wire [33:0] after;
	wire over;
	wire [33:0] excess_amt;
	wire [33:0] next_level;
	assign frac_sum = {1'b0, frac} + {1'b0, rate[15:0]};
	assign fill = {2'b00, level} + {18'h00000, rate[31:16]} + {33'h0, frac_sum[16]} + {2'b00, spill_in}; // see [R3]
	assign after = take ? fill - {18'h00000, take_len} : fill; // see [R1]
	assign over = after > {2'b00, size};
	assign excess_amt = after - {2'b00, size};
	assign next_level = over ? {2'b00, size} : after; // see [R2]
	assign spill_out = over ? excess_amt[31:0] : 32'h0000_0000;
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			level <= 32'h0000_0000;
			frac <= 16'h0000;
		end
		else if (ce)
		begin
			level <= next_level[31:0];
			frac <= frac_sum[15:0];
		end
	end
endmodule

/* tbp_marker.v */
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_marker(
	input wire [1:0] colour,
	input wire mark_en,
	input wire [5:0] red_code,
	input wire [5:0] yellow_code,
	input wire [7:0] ds_in,
	output reg [7:0] ds_out
);
	// the two low ds bits belong to other protocols and pass through
	always @*
	begin
		ds_out = ds_in;
		if (mark_en && colour == `TBP_COLOUR_RED)
			ds_out = {red_code, ds_in[1:0]}; // see [R19]
		else if (mark_en && colour == `TBP_COLOUR_YELLOW)
			ds_out = {yellow_code, ds_in[1:0]}; // see [R19]
	end
endmodule

/* tbp_top.v */
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_top(
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire pkt_valid,
	input wire [15:0] pkt_len,
	input wire [7:0] pkt_ds,
	output reg pkt_ready,
	output reg out_valid,
	output reg out_pass,
	output reg out_drop,
	output reg [1:0] out_colour,
	output reg [15:0] out_len,
	output reg [7:0] out_ds
);
	localparam ST_IDLE = 1'b0;
	localparam ST_EVAL = 1'b1;

	reg [31:0] ctrl;
	reg [31:0] committed_rate;
	reg [31:0] peak_rate;
	reg [31:0] committed_bucket;
	reg [31:0] excess_bucket;
	reg [31:0] peak_bucket;
	reg [31:0] dscp_codes;
	reg [31:0] cnt_green;
	reg [31:0] cnt_yellow;
	reg [31:0] cnt_red;
	reg [31:0] cnt_drop;
	reg state;
	reg [15:0] hold_len;
	reg [7:0] hold_ds;

	wire [1:0] mode;
	wire police_mark;
	wire red_drop;
	wire [31:0] level_c;
	wire [31:0] level_s;
	wire [31:0] spill_c;
	wire [31:0] second_rate;
	wire [31:0] second_size;
	wire [31:0] second_spill;
	wire [7:0] marked_ds;
	wire fit_c;
	wire fit_s;

	reg done;
	reg [1:0] colour;
	reg drop;
	reg take_c;
	reg take_s;
	reg next_state;
	reg [31:0] next_rdata;

	function fits;
		input [31:0] lvl;
		input [15:0] len;
		begin
			fits = lvl >= {16'h0000, len};
		end
	endfunction

	assign mode = ctrl[`TBP_CTRL_MODE_HI:`TBP_CTRL_MODE_LO]; // see [R21]
	assign police_mark = ctrl[`TBP_CTRL_POLICE_MARK];
	assign red_drop = ctrl[`TBP_CTRL_RED_DROP];
	assign fit_c = fits(level_c, hold_len); // see [R4]
	assign fit_s = fits(level_s, hold_len);

	// the second bucket is the excess bucket in single rate mode and the peak bucket in two rate mode
	assign second_rate = (mode == `TBP_MODE_TWO_RATE_THREE_COLOUR_MODE) ? peak_rate : 32'h0000_0000; // see [R15]
	assign second_size = (mode == `TBP_MODE_TWO_RATE_THREE_COLOUR_MODE) ? peak_bucket : excess_bucket;
	assign second_spill = (mode == `TBP_MODE_SINGLE_RATE_THREE_COLOUR_MODE) ? spill_c : 32'h0000_0000; // see [R9]

	tbp_bucket u_committed(
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ce(ce),
		.rate(committed_rate),
		.size(committed_bucket),
		.spill_in(32'h0000_0000),
		.take(take_c),
		.take_len(hold_len),
		.level(level_c),
		.spill_out(spill_c)
	);

	tbp_bucket u_second(
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ce(ce),
		.rate(second_rate),
		.size(second_size),
		.spill_in(second_spill),
		.take(take_s),
		.take_len(hold_len),
		.level(level_s),
		.spill_out()
	);

	tbp_marker u_marker(
		.colour(colour),
		.mark_en(!drop),
		.red_code(dscp_codes[5:0]),
		.yellow_code(dscp_codes[13:8]),
		.ds_in(hold_ds),
		.ds_out(marked_ds)
	);

	// decision on the held descriptor; tokens are only deducted when a packet leaves undropped
	always @*
	begin
		done = 1'b0;
		colour = `TBP_COLOUR_GREEN;
		drop = 1'b0;
		take_c = 1'b0;
		take_s = 1'b0;
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (pkt_valid && pkt_ready)
					next_state = ST_EVAL;
			end
			ST_EVAL:
			begin
				done = 1'b1;
				case (mode)
					`TBP_MODE_SHAPE:
					begin
						if (fit_c)
							take_c = 1'b1; // see [R5]
						else
							done = 1'b0; // see [R6]
					end
					`TBP_MODE_POLICE:
					begin
						if (fit_c)
							take_c = 1'b1; // see [R5]
						else
						begin
							colour = `TBP_COLOUR_RED;
							drop = !police_mark; // see [R7]
						end
					end
					`TBP_MODE_SINGLE_RATE_THREE_COLOUR_MODE:
					begin
						if (fit_c)
							take_c = 1'b1; // see [R10] [R11]
						else if (fit_s)
						begin
							colour = `TBP_COLOUR_YELLOW; // see [R12]
							take_s = 1'b1;
						end
						else
						begin
							colour = `TBP_COLOUR_RED; // see [R12]
							drop = red_drop; // see [R13]
						end
					end
					`TBP_MODE_TWO_RATE_THREE_COLOUR_MODE:
					begin
						if (!fit_s)
						begin
							colour = `TBP_COLOUR_RED; // see [R17]
							drop = red_drop; // see [R13]
						end
						else if (fit_c)
						begin
							take_c = 1'b1; // see [R18] [R20]
							take_s = 1'b1;
						end
						else
						begin
							colour = `TBP_COLOUR_YELLOW; // see [R18]
							take_s = 1'b1; // see [R20]
						end
					end
					default:
					begin
						done = 1'b0;
					end
				endcase
				if (done)
					next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			pkt_ready <= 1'b0;
			hold_len <= 16'h0000;
			hold_ds <= 8'h00;
			out_valid <= 1'b0;
			out_pass <= 1'b0;
			out_drop <= 1'b0;
			out_colour <= `TBP_COLOUR_GREEN;
			out_len <= 16'h0000;
			out_ds <= 8'h00;
		end
		else if (ce)
		begin
			state <= next_state;
			pkt_ready <= (next_state == ST_IDLE);
			out_valid <= done;
			if (pkt_valid && pkt_ready)
			begin
				hold_len <= pkt_len;
				hold_ds <= pkt_ds;
			end
			if (done)
			begin
				out_pass <= !drop;
				out_drop <= drop;
				out_colour <= colour; // see [R14]
				out_len <= hold_len;
				out_ds <= marked_ds;
			end
		end
	end

	// statistics wrap silently; software samples the difference
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_green <= 32'h0000_0000;
			cnt_yellow <= 32'h0000_0000;
			cnt_red <= 32'h0000_0000;
			cnt_drop <= 32'h0000_0000;
		end
		else if (ce && done)
		begin
			if (colour == `TBP_COLOUR_GREEN)
				cnt_green <= cnt_green + 32'h0000_0001;
			if (colour == `TBP_COLOUR_YELLOW)
				cnt_yellow <= cnt_yellow + 32'h0000_0001;
			if (colour == `TBP_COLOUR_RED)
				cnt_red <= cnt_red + 32'h0000_0001;
			if (drop)
				cnt_drop <= cnt_drop + 32'h0000_0001;
		end
	end

	// configuration; a rate or size change takes effect on the next cycle's refill
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl <= `TBP_CTRL_RESET;
			committed_rate <= `TBP_RATE_RESET;
			peak_rate <= `TBP_RATE_RESET;
			committed_bucket <= `TBP_SIZE_RESET;
			excess_bucket <= `TBP_SIZE_RESET;
			peak_bucket <= `TBP_SIZE_RESET;
			dscp_codes <= `TBP_DSCP_RESET;
		end
		else if (ce && reg_wr)
		begin
			case (reg_addr)
				`TBP_ADDR_CTRL:
					ctrl <= {28'h0000000, reg_wdata[3:0]};
				`TBP_ADDR_COMMITTED_RATE:
					committed_rate <= reg_wdata;
				`TBP_ADDR_PEAK_RATE:
					peak_rate <= reg_wdata; // see [R16]
				`TBP_ADDR_COMMITTED_BUCKET:
					committed_bucket <= reg_wdata; // see [R8]
				`TBP_ADDR_EXCESS_BUCKET:
					excess_bucket <= reg_wdata;
				`TBP_ADDR_PEAK_BUCKET:
					peak_bucket <= reg_wdata;
				`TBP_ADDR_DSCP:
					dscp_codes <= {18'h00000, reg_wdata[13:8], 2'b00, reg_wdata[5:0]};
				default:
				begin
				end
			endcase
		end
	end

	always @*
	begin
		next_rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				`TBP_ADDR_CTRL:
					next_rdata = ctrl;
				`TBP_ADDR_COMMITTED_RATE:
					next_rdata = committed_rate;
				`TBP_ADDR_PEAK_RATE:
					next_rdata = peak_rate;
				`TBP_ADDR_COMMITTED_BUCKET:
					next_rdata = committed_bucket;
				`TBP_ADDR_EXCESS_BUCKET:
					next_rdata = excess_bucket;
				`TBP_ADDR_PEAK_BUCKET:
					next_rdata = peak_bucket;
				`TBP_ADDR_DSCP:
					next_rdata = dscp_codes;
				`TBP_ADDR_LEVEL_C:
					next_rdata = level_c;
				`TBP_ADDR_LEVEL_S:
					next_rdata = level_s;
				`TBP_ADDR_CNT_GREEN:
					next_rdata = cnt_green;
				`TBP_ADDR_CNT_YELLOW:
					next_rdata = cnt_yellow;
				`TBP_ADDR_CNT_RED:
					next_rdata = cnt_red;
				`TBP_ADDR_CNT_DROP:
					next_rdata = cnt_drop;
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 32'h0000_0000;
		else if (ce)
			reg_rdata <= next_rdata;
	end
endmodule

/* tbp_chk.sv */
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_chk(
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire pkt_valid,
	input wire [15:0] pkt_len,
	input wire [7:0] pkt_ds,
	input wire pkt_ready,
	input wire out_valid,
	input wire out_pass,
	input wire out_drop,
	input wire [1:0] out_colour,
	input wire [15:0] out_len,
	input wire [7:0] out_ds
);
reg [15:0] len_t;
reg [7:0] ds_t;
wire take = pkt_valid && pkt_ready && ce;
// the descriptor bus is scrambled after the take, so keep our own copy
always @(posedge clk_sys or negedge resetn)
begin
	if (!resetn)
	begin
		len_t <= 16'h0000;
		ds_t <= 8'h00;
	end
	else if (take)
	begin
		len_t <= pkt_len;
		ds_t <= pkt_ds;
	end
end
default clocking @(posedge clk_sys); endclocking
default disable iff (!resetn);
take_busy_a:
assert property (take |=> !pkt_ready && !out_valid) else $error("busy after take");
// a frozen clock enable legally stretches the strobe, so only a running edge must end it
one_pulse_a:
assert property (out_valid && ce |=> !out_valid) else $error("decision too long");
ready_back_a:
assert property (out_valid |-> pkt_ready) else $error("not ready at decision");
pass_drop_a:
assert property (out_valid |-> out_pass != out_drop) else $error("pass and drop agree");
colour_code_a:
assert property (out_valid |-> out_colour != 2'h3) else $error("bad colour");
green_pass_a:
assert property (out_valid && out_colour == `TBP_COLOUR_GREEN |-> out_pass && out_ds == ds_t)
	else $error("green not clean");
len_echo_a:
assert property (out_valid |-> out_len == len_t) else $error("length lost");
ds_low_a:
assert property (out_valid |-> out_ds[1:0] == ds_t[1:0]) else $error("low ds bits changed");
endmodule
bind tbp_top tbp_chk i_chk(.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .pkt_valid(pkt_valid),
	.pkt_len(pkt_len), .pkt_ds(pkt_ds), .pkt_ready(pkt_ready), .out_valid(out_valid),
	.out_pass(out_pass), .out_drop(out_drop), .out_colour(out_colour), .out_len(out_len), .out_ds(out_ds));

/* tbp_src.sv */
`timescale 1ns/10ps
module tbp_src(
	input wire clk_sys,
	input wire pkt_ready,
	output reg pkt_valid,
	output reg [15:0] pkt_len,
	output reg [7:0] pkt_ds
);
initial
begin
	pkt_valid = 1'b0;
	pkt_len = 16'h0000;
	pkt_ds = 8'h00;
end
// hold until taken, then scramble so a stale bus is never reused
task send(input [15:0] len, input [7:0] ds);
begin
	pkt_valid <= 1'b1;
	pkt_len <= len;
	pkt_ds <= ds;
	@(posedge clk_sys);
	while (!pkt_ready)
		@(posedge clk_sys);
	pkt_valid <= 1'b0;
	pkt_len <= ~len;
	pkt_ds <= ~ds;
end
endtask
endmodule

/* tb.sv */
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tb;
reg clk_sys;
reg resetn;
reg [7:0] reg_addr;
reg [31:0] reg_wdata;
reg reg_wr;
reg reg_rd;
reg ce;
wire [31:0] reg_rdata;
wire pkt_valid, pkt_ready, out_valid, out_pass, out_drop;
wire [15:0] pkt_len, out_len;
wire [7:0] pkt_ds, out_ds;
wire [1:0] out_colour;
integer error_cnt = 0;
integer num_checks = 0;
integer n;
tbp_top i_tbp_top(.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pkt_valid(pkt_valid), .pkt_len(pkt_len), .pkt_ds(pkt_ds), .pkt_ready(pkt_ready),
	.out_valid(out_valid), .out_pass(out_pass), .out_drop(out_drop), .out_colour(out_colour),
	.out_len(out_len), .out_ds(out_ds));
tbp_src i_src(.clk_sys(clk_sys), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid),
	.pkt_len(pkt_len), .pkt_ds(pkt_ds));
initial
begin
	clk_sys = 1'b0;
	forever
		#2.5 clk_sys = ~clk_sys;
end
task chk(input [47:0] what, input [31:0] exp, input [31:0] got);
begin
	num_checks = num_checks + 1;
	if (got !== exp)
	begin
		error_cnt = error_cnt + 1;
		$display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
	end
end
endtask
task summarize;
begin
	$display("checks %0d mismatches %0d", num_checks, error_cnt);
	if (error_cnt == 0 && num_checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
end
endtask
// a gap cycle after each strobe keeps one assignment per time step
task wr(input [7:0] a, input [31:0] d);
begin
	reg_wr <= 1'b1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clk_sys);
	reg_wr <= 1'b0;
	@(posedge clk_sys);
end
endtask
task rd(input [7:0] a, input [31:0] exp);
begin
	reg_rd <= 1'b1;
	reg_addr <= a;
	@(posedge clk_sys);
	reg_rd <= 1'b0;
	#1;
	chk("rdata", exp, reg_rdata);
	@(posedge clk_sys);
end
endtask
task pkt(input [15:0] len, input [7:0] ds, input ps, input [1:0] col, input [7:0] eds);
begin
	i_src.send(len, ds);
	n = 0;
	while (out_valid !== 1'b1 && n < 300)
	begin
		@(posedge clk_sys);
		#1;
		n = n + 1;
	end
	chk("valid", 1, out_valid);
	chk("pass", ps, out_pass);
	chk("drop", !ps, out_drop);
	chk("colour", col, out_colour);
	chk("len", len, out_len);
	chk("ds", eds, out_ds);
	@(posedge clk_sys);
end
endtask
// rate 0 freezes the levels so every expectation is exact
task t_police;
begin
	rd(`TBP_ADDR_COMMITTED_RATE, `TBP_RATE_RESET);
	rd(8'hFC, 0);
	wr(`TBP_ADDR_COMMITTED_BUCKET, 100);
	wr(`TBP_ADDR_CTRL, `TBP_MODE_POLICE);
	repeat (150) @(posedge clk_sys);
	wr(`TBP_ADDR_COMMITTED_RATE, 0);
	rd(`TBP_ADDR_LEVEL_C, 100);
	pkt(60, 8'h03, 1, `TBP_COLOUR_GREEN, 8'h03);
	pkt(60, 8'h03, 0, `TBP_COLOUR_RED, 8'h03);
	rd(`TBP_ADDR_LEVEL_C, 40);
	wr(`TBP_ADDR_DSCP, 32'h0000_152A);
	wr(`TBP_ADDR_CTRL, 32'h0000_0005);
	pkt(60, 8'h03, 1, `TBP_COLOUR_RED, 8'hAB);
	pkt(40, 8'h00, 1, `TBP_COLOUR_GREEN, 8'h00);
	rd(`TBP_ADDR_LEVEL_C, 0);
	$display("police test done");
end
endtask
task t_shape;
begin
	wr(`TBP_ADDR_CTRL, `TBP_MODE_SHAPE);
	wr(`TBP_ADDR_COMMITTED_RATE, `TBP_RATE_RESET);
	pkt(30, 8'h10, 1, `TBP_COLOUR_GREEN, 8'h10);
	chk("wait", 1, n > 20);
	$display("shape test done");
end
endtask
task t_single;
begin
	wr(`TBP_ADDR_EXCESS_BUCKET, 50);
	wr(`TBP_ADDR_CTRL, 32'h0000_000A);
	repeat (300) @(posedge clk_sys);
	wr(`TBP_ADDR_COMMITTED_RATE, 0);
	rd(`TBP_ADDR_LEVEL_S, 50);
	pkt(100, 8'h00, 1, `TBP_COLOUR_GREEN, 8'h00);
	pkt(50, 8'h01, 1, `TBP_COLOUR_YELLOW, 8'h55);
	pkt(10, 8'h00, 0, `TBP_COLOUR_RED, 8'h00);
	rd(`TBP_ADDR_LEVEL_C, 0);
	rd(`TBP_ADDR_LEVEL_S, 0);
	$display("single rate test done");
end
endtask
task t_two;
begin
	wr(`TBP_ADDR_COMMITTED_BUCKET, 50);
	wr(`TBP_ADDR_PEAK_BUCKET, 100);
	wr(`TBP_ADDR_CTRL, 32'h0000_000B);
	wr(`TBP_ADDR_COMMITTED_RATE, `TBP_RATE_RESET);
	repeat (150) @(posedge clk_sys);
	wr(`TBP_ADDR_COMMITTED_RATE, 0);
	wr(`TBP_ADDR_PEAK_RATE, 0);
	pkt(120, 8'h00, 0, `TBP_COLOUR_RED, 8'h00);
	pkt(40, 8'h00, 1, `TBP_COLOUR_GREEN, 8'h00);
	pkt(40, 8'h02, 1, `TBP_COLOUR_YELLOW, 8'h56);
	rd(`TBP_ADDR_LEVEL_C, 10);
	rd(`TBP_ADDR_LEVEL_S, 20);
	$display("two rate test done");
end
endtask
// a write while the clock enable is low must be lost; counters cover every packet so far
task t_hold;
begin
	ce <= 1'b0;
	wr(`TBP_ADDR_CTRL, `TBP_MODE_SHAPE);
	ce <= 1'b1;
	rd(`TBP_ADDR_CTRL, 32'h0000_000B);
	rd(`TBP_ADDR_CNT_GREEN, 5);
	rd(`TBP_ADDR_CNT_YELLOW, 2);
	rd(`TBP_ADDR_CNT_RED, 4);
	rd(`TBP_ADDR_CNT_DROP, 3);
	$display("hold and count test done");
end
endtask
initial
begin
	#50000;
	error_cnt = error_cnt + 1;
	summarize;
end
initial
begin
	resetn = 1'b0;
	ce = 1'b1;
	reg_addr = 8'h00;
	reg_wdata = 32'h0;
	reg_wr = 1'b0;
	reg_rd = 1'b0;
	repeat (20) @(posedge clk_sys);
	resetn <= 1'b1;
	@(posedge clk_sys);
	t_police;
	t_shape;
	t_single;
	t_two;
	t_hold;
	summarize;
end
endmodule
